// ---- cpu_move_ret_defs.svh ----
`ifndef CPU_MOVE_RET_DEFS_SVH
`define CPU_MOVE_RET_DEFS_SVH

// Register byte offsets (word aligned)
`define ADR_INSTR 12'h000
`define ADR_ACC 12'h004
`define ADR_STATUS 12'h008
`define ADR_PC 12'h00C
`define ADR_IRQ_CTRL 12'h010
`define ADR_STACK 12'h014
`define ADR_STACK_HEAD 12'h018
`define ADR_FILE_BASE 12'h200

// Instruction word fields
`define INSTR_W 11
`define INSTR_OP_MSB 10
`define INSTR_OP_LSB 8
`define INSTR_DEST_BIT 7

// Operation codes
`define OP_IDLE 3'h0
`define OP_MOVE_FILE 3'h1
`define OP_STORE_ACC 3'h2
`define OP_LOAD_LITERAL 3'h3
`define OP_IRQ_RETURN 3'h4
`define OP_LITERAL_RETURN 3'h5

// Status and control bit positions
`define STAT_ZERO_BIT 0
`define STAT_BUSY_BIT 1
`define IRQ_MASTER_BIT 7

// Reset values
`define ACC_RST 8'h00
`define IRQ_CTRL_RST 8'h00
`define PC_RST 13'h0000

`endif

// ---- cpu_move_ret_pkg.sv ----
package cpu_move_ret_pkg;

  typedef enum logic [1:0] {
    ST_READY,
    ST_EXEC,
    ST_FLUSH
  } exec_state_t;

  typedef logic [2:0] op_t;
  typedef logic [6:0] file_idx_t;

endpackage

// ---- return_stack.sv ----
`timescale 1ns/10ps

module return_stack #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Push and pop
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  input wire logic pop_i,
  // State
  output logic [WIDTH-1:0] head_o,
  output logic [CNT_W-1:0] depth_o
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] ptr_ff;
  logic [CNT_W-1:0] depth_ff;
  logic [PTR_W-1:0] top_idx;

  assign top_idx = ptr_ff - 1'b1;
  assign head_o = mem[top_idx];
  assign depth_o = depth_ff;

  // Circular: overflow overwrites the oldest entry, underflow wraps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_ff <= '0;
    end else if (push_i) begin
      ptr_ff <= ptr_ff + 1'b1;
    end else if (pop_i) begin
      ptr_ff <= top_idx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      depth_ff <= '0;
    end else if (push_i && depth_ff != CNT_W'(DEPTH)) begin
      depth_ff <= depth_ff + 1'b1;
    end else if (!push_i && pop_i && depth_ff != '0) begin
      depth_ff <= depth_ff - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_i) begin
      mem[ptr_ff] <= push_data_i;
    end
  end

endmodule

// ---- cpu_move_ret_core.sv ----
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`include "cpu_move_ret_defs.svh"

// Functional notes
// - move_file_op copies file to accumulator or itself
// - move_file_op updates zero flag from value
// - move_file_op: 7-bit index, one cycle
// - store_acc_op writes file, flags untouched, one cycle
// - load_literal_op loads 8-bit literal, flags untouched
// - irq_return_op pops stack_head into PC, two cycles
// - irq_return_op sets master_irq_on bit seven
// - literal_return_op loads literal, pops PC, two cycles
module cpu_move_ret_core
  import cpu_move_ret_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS = 128
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Core state
  output logic master_irq_on_o,
  output logic [PC_W-1:0] pc_o,
  output logic [7:0] acc_o
);

  localparam int CNT_W = $clog2(STACK_DEPTH + 1);

  exec_state_t state_ff;
  logic [`INSTR_W-1:0] instr_ff;
  logic [7:0] acc_ff;
  logic zero_ff;
  logic [PC_W-1:0] pc_ff;
  logic [7:0] irq_ctrl_ff;
  logic [7:0] file_mem [FILE_WORDS];
  logic ack_ff;
  logic [31:0] dat_ff;

  logic req;
  logic bus_wr;
  logic busy;
  logic exec;
  op_t op;
  file_idx_t f_idx;
  logic dest_file;
  logic [7:0] literal;
  logic [7:0] file_val;
  logic is_return;
  logic [PC_W-1:0] stack_head;
  logic [CNT_W-1:0] stack_depth;
  logic stack_pop;
  logic stack_push;

  // Word register hit at a given byte offset
  function automatic logic reg_hit(input logic [11:0] adr, input logic [11:0] off);
    reg_hit = (adr[11:2] == off[11:2]);
  endfunction

  // File register window occupies 0x200 to 0x3FF, one eighth of the map
  function automatic logic file_hit(input logic [11:0] adr);
    file_hit = (adr[11:9] == 3'(`ADR_FILE_BASE >> 9));
  endfunction

  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master sees ack; low byte lane required
  assign bus_wr = req & ack_ff & wb_we_i & wb_sel_i[0];
  assign busy = (state_ff != ST_READY);
  assign exec = (state_ff == ST_EXEC);
  assign op = instr_ff[`INSTR_OP_MSB:`INSTR_OP_LSB];
  assign f_idx = instr_ff[6:0];
  assign dest_file = instr_ff[`INSTR_DEST_BIT];
  assign literal = instr_ff[7:0];
  assign file_val = file_mem[f_idx];
  assign is_return = (op == `OP_IRQ_RETURN) || (op == `OP_LITERAL_RETURN);
  assign stack_pop = exec & is_return;
  assign stack_push = bus_wr & reg_hit(wb_adr_i, `ADR_STACK) & ~busy;

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W),
    .CNT_W(CNT_W)
  ) u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(stack_push),
    .push_data_i(wb_dat_i[PC_W-1:0]),
    .pop_i(stack_pop),
    .head_o(stack_head),
    .depth_o(stack_depth)
  );

  // Issue while busy is dropped so a half-done return is never disturbed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_ff <= '0;
    end else if (bus_wr && reg_hit(wb_adr_i, `ADR_INSTR) && !busy) begin
      instr_ff <= wb_dat_i[`INSTR_W-1:0];
    end
  end

  // returns take a second, flushing cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_READY;
    end else begin
      case (state_ff)
        ST_READY: begin
          if (bus_wr && reg_hit(wb_adr_i, `ADR_INSTR)) begin
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          state_ff <= is_return ? ST_FLUSH : ST_READY;
        end
        ST_FLUSH: begin
          state_ff <= ST_READY;
        end
        default: begin
          state_ff <= ST_READY;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_ff <= `ACC_RST;
    end else if (exec) begin
      case (op)
        `OP_MOVE_FILE: begin
          if (!dest_file) begin
            acc_ff <= file_val;
          end
        end
        `OP_LOAD_LITERAL: begin
          acc_ff <= literal;
        end
        `OP_LITERAL_RETURN: begin
          acc_ff <= literal;
        end
        default: begin
          acc_ff <= acc_ff;
        end
      endcase
    end else if (bus_wr && reg_hit(wb_adr_i, `ADR_ACC) && !busy) begin
      acc_ff <= wb_dat_i[7:0];
    end
  end

  // Only move_file_op touches the zero flag; all other ops leave it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_ff <= 1'b0;
    end else if (exec && op == `OP_MOVE_FILE) begin
      zero_ff <= (file_val == 8'h00);
    end else if (bus_wr && reg_hit(wb_adr_i, `ADR_STATUS) && !busy) begin
      zero_ff <= wb_dat_i[`STAT_ZERO_BIT];
    end
  end

  // File array carries no reset, as a real register file would not
  always_ff @(posedge clk_i) begin
    if (exec && op == `OP_STORE_ACC) begin
      file_mem[f_idx] <= acc_ff;
    end else if (exec && op == `OP_MOVE_FILE && dest_file) begin
      file_mem[f_idx] <= file_val;
    end else if (bus_wr && file_hit(wb_adr_i) && !busy) begin
      file_mem[wb_adr_i[8:2]] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_ff <= `PC_RST;
    end else if (exec) begin
      if (is_return) begin
        pc_ff <= stack_head;
      end else begin
        // all non-return ops just advance PC
        pc_ff <= pc_ff + 1'b1;
      end
    end else if (bus_wr && reg_hit(wb_adr_i, `ADR_PC) && !busy) begin
      pc_ff <= wb_dat_i[PC_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ctrl_ff <= `IRQ_CTRL_RST;
    end else if (exec && op == `OP_IRQ_RETURN) begin
      irq_ctrl_ff[`IRQ_MASTER_BIT] <= 1'b1;
    end else if (bus_wr && reg_hit(wb_adr_i, `ADR_IRQ_CTRL) && !busy) begin
      irq_ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff) begin
      dat_ff <= 32'h0000_0000;
      if (reg_hit(wb_adr_i, `ADR_INSTR)) begin
        dat_ff[`INSTR_W-1:0] <= instr_ff;
      end else if (reg_hit(wb_adr_i, `ADR_ACC)) begin
        dat_ff[7:0] <= acc_ff;
      end else if (reg_hit(wb_adr_i, `ADR_STATUS)) begin
        dat_ff[`STAT_ZERO_BIT] <= zero_ff;
        dat_ff[`STAT_BUSY_BIT] <= busy;
      end else if (reg_hit(wb_adr_i, `ADR_PC)) begin
        dat_ff[PC_W-1:0] <= pc_ff;
      end else if (reg_hit(wb_adr_i, `ADR_IRQ_CTRL)) begin
        dat_ff[7:0] <= irq_ctrl_ff;
      end else if (reg_hit(wb_adr_i, `ADR_STACK)) begin
        dat_ff[CNT_W-1:0] <= stack_depth;
      end else if (reg_hit(wb_adr_i, `ADR_STACK_HEAD)) begin
        dat_ff[PC_W-1:0] <= stack_head;
      end else if (file_hit(wb_adr_i)) begin
        dat_ff[7:0] <= file_mem[wb_adr_i[8:2]];
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign master_irq_on_o = irq_ctrl_ff[`IRQ_MASTER_BIT];
  assign pc_o = pc_ff;
  assign acc_o = acc_ff;

endmodule

// ---- cpu_move_ret_core_sva.sv ----
`timescale 1ns/10ps
module cpu_move_ret_core_sva #(
  parameter int PC_W = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic master_irq_on_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [7:0] acc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic iw;
  logic [2:0] op;
  logic [7:0] lit;
  // Instruction word landing this cycle; execution shows two samples later
  assign iw = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
    wb_adr_i[11:2] == 10'h000;
  assign op = wb_dat_i[10:8];
  assign lit = wb_dat_i[7:0];
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  literal_load_a: assert property (iw && op == 3'h3 |-> ##2 acc_o == $past(lit, 2))
    else $error("literal not in accumulator");
  idle_step_a: assert property (iw && op == 3'h0 |-> ##2
    pc_o == PC_W'($past(pc_o, 2) + 1'b1) && acc_o == $past(acc_o, 2))
    else $error("idle changed state");
  store_keep_a: assert property (iw && op == 3'h2 |-> ##2
    acc_o == $past(acc_o, 2) && pc_o == PC_W'($past(pc_o, 2) + 1'b1))
    else $error("store altered accumulator");
  file_self_a: assert property (iw && op == 3'h1 && wb_dat_i[7] |-> ##2
    acc_o == $past(acc_o, 2))
    else $error("self move touched accumulator");
  irq_enable_a: assert property (iw && op == 3'h4 |-> ##2 master_irq_on_o)
    else $error("interrupts not enabled on return");
  lit_return_a: assert property (iw && op == 3'h5 |-> ##2 acc_o == $past(lit, 2))
    else $error("return literal missing");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=> pc_o == '0 && acc_o == 8'h00)
    else $error("state not cleared by reset");
  cover property (iw && op == 3'h4);
  cover property (iw && op == 3'h5);
  cover property (iw && op == 3'h1 && wb_dat_i[7]);
endmodule

// ---- cpu_move_and_return_ops_test.sv ----
`timescale 1ns/10ps
`include "cpu_move_ret_defs.svh"
module cpu_move_and_return_ops_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] q;
  logic [31:0] dat_o;
  logic ack;
  logic irq_on;
  logic [12:0] pc;
  logic [7:0] acc;
  int num_errors = 0;
  int tests_run = 0;
  int polls = 0;
  always #10 clk_i = ~clk_i;
  cpu_move_ret_core dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .master_irq_on_o(irq_on), .pc_o(pc), .acc_o(acc));
  task wrap_up;
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task check(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Called just after a rising edge; holds the request until ack is sampled
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      wrap_up();
    end
    @(posedge clk_i);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    check(n, q, e);
  endtask
  // Returns stay busy an extra cycle, so poll status before going on
  task ex(input logic [31:0] w);
    int n;
    wr(`ADR_INSTR, w);
    n = 0;
    do begin
      bus(1'b0, `ADR_STATUS, 32'h0000_0000);
      n++;
    end while (q[1] !== 1'b0 && n < 10);
    polls = n;
    if (n >= 10) begin
      num_errors++;
      wrap_up();
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("acc", `ADR_ACC, 32'h0000_0000);
    rd("pc", `ADR_PC, 32'h0000_0000);
    rd("irq_ctrl", `ADR_IRQ_CTRL, 32'h0000_0000);
    $display("reset test done");
    wr(`ADR_STATUS, 32'h0000_0001);
    ex(32'h0000_03FF);
    check("cycles", polls, 32'h0000_0001);
    rd("acc", `ADR_ACC, 32'h0000_00FF);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    ex(32'h0000_027F);
    check("cycles", polls, 32'h0000_0001);
    rd("file127", 12'h3FC, 32'h0000_00FF);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    rd("pc", `ADR_PC, 32'h0000_0002);
    $display("load and store test done");
    ex(32'h0000_0300);
    ex(32'h0000_017F);
    check("cycles", polls, 32'h0000_0001);
    rd("acc", `ADR_ACC, 32'h0000_00FF);
    rd("zero", `ADR_STATUS, 32'h0000_0000);
    wr(12'h214, 32'h0000_0000);
    ex(32'h0000_0185);
    rd("file5", 12'h214, 32'h0000_0000);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    rd("acc", `ADR_ACC, 32'h0000_00FF);
    check("acc_o", 32'(acc), 32'h0000_00FF);
    $display("move test done");
    sel <= 4'hE;
    wr(`ADR_ACC, 32'h0000_0011);
    sel <= 4'hF;
    rd("acc_sel", `ADR_ACC, 32'h0000_00FF);
    $display("byte lane test done");
    wr(`ADR_PC, 32'h0000_0FFF);
    ex(32'h0000_0000);
    check("cycles", polls, 32'h0000_0001);
    rd("pc", `ADR_PC, 32'h0000_1000);
    rd("acc", `ADR_ACC, 32'h0000_00FF);
    ex(32'h0000_0700);
    check("pc_o", 32'(pc), 32'h0000_1001);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    $display("idle test done");
    wr(`ADR_IRQ_CTRL, 32'h0000_0001);
    wr(`ADR_STACK, 32'h0000_0123);
    ex(32'h0000_0400);
    check("cycles", polls, 32'h0000_0002);
    check("irq_on", 32'(irq_on), 32'h0000_0001);
    check("pc_o", 32'(pc), 32'h0000_0123);
    rd("pc", `ADR_PC, 32'h0000_0123);
    rd("irq_ctrl", `ADR_IRQ_CTRL, 32'h0000_0081);
    rd("depth", `ADR_STACK, 32'h0000_0000);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    wr(`ADR_STACK, 32'h0000_00AB);
    rd("depth", `ADR_STACK, 32'h0000_0001);
    rd("head", `ADR_STACK_HEAD, 32'h0000_00AB);
    ex(32'h0000_053C);
    check("cycles", polls, 32'h0000_0002);
    check("acc_o", 32'(acc), 32'h0000_003C);
    rd("instr", `ADR_INSTR, 32'h0000_053C);
    rd("acc", `ADR_ACC, 32'h0000_003C);
    rd("pc", `ADR_PC, 32'h0000_00AB);
    rd("zero", `ADR_STATUS, 32'h0000_0001);
    rd("unmapped", 12'h100, 32'h0000_0000);
    $display("return test done");
    wr(`ADR_STACK, 32'h0000_0055);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("acc", `ADR_ACC, 32'h0000_0000);
    rd("pc", `ADR_PC, 32'h0000_0000);
    rd("irq_ctrl", `ADR_IRQ_CTRL, 32'h0000_0000);
    rd("zero", `ADR_STATUS, 32'h0000_0000);
    rd("depth", `ADR_STACK, 32'h0000_0000);
    check("irq_on", 32'(irq_on), 32'h0000_0000);
    $display("second reset test done");
    wrap_up();
  end
endmodule
bind cpu_move_ret_core cpu_move_ret_core_sva #(.PC_W(PC_W)) sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .master_irq_on_o(master_irq_on_o), .pc_o(pc_o), .acc_o(acc_o));
